// >>> design/asb_pkg.sv
// Package for the converter sequencer: register map, field layout, timing.
// Assumes a 25 MHz APB clock and 32-bit register words.
package asb_pkg;
   // Register byte offsets
   localparam logic [3:0] CSR_OFS = 4'h0;
   localparam logic [3:0] RES_OFS = 4'h4;
   localparam logic [3:0] STS_OFS = 4'h8;
   localparam logic [3:0] MSK_OFS = 4'hc;
   localparam int OFS_W = 4;

   // Widths
   localparam int GAIN_W = 2;
   localparam int CHAN_W = 6;
   localparam int RESULT_W = 10;
   localparam int STS_W = 2;
   localparam int MAX_GROUPS = 8;
   localparam int GRP_LSB = 2;
   localparam int GRP_W = 3;

   // Control and status word layout
   localparam int CSR_GAIN_LSB = 0;
   localparam int CSR_CHAN_LSB = 2;
   localparam int CSR_IE_BIT = 8;
   localparam int CSR_EXT_BIT = 9;
   localparam int CSR_SEL_BIT = 10;
   localparam int CSR_BUSY_BIT = 13;
   localparam int CSR_ERR_BIT = 14;
   localparam int CSR_DONE_BIT = 15;

   // Event status and mask layout
   localparam int STS_DONE_BIT = 0;
   localparam int STS_ERR_BIT = 1;

   // Reset values
   localparam logic [STS_W-1:0] STS_RST = 2'h0;
   localparam logic [STS_W-1:0] MSK_RST = 2'h0;
   localparam logic [31:0] RD_RST = 32'h0;

   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS = 22000;
   localparam int BIP_EXTRA_NS = 7000;
   localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int BIP_CYC = (CONV_TIME_NS + BIP_EXTRA_NS) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      GAIN_1V25 = 2'b00,
      GAIN_2V5 = 2'b01,
      GAIN_5V = 2'b10,
      GAIN_10V = 2'b11
   } asb_gain_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } asb_state_t;

   typedef struct packed {
      logic [CHAN_W-1:0] channel;
      asb_gain_t gain;
   } asb_cmd_t;

   typedef struct packed {
      logic ext_sel;
      logic ext_en;
      logic ie;
   } asb_mode_t;
endpackage

// >>> design/asb_conv_timer.sv
// Conversion interval timer for the converter sequencer.
// Assumes start is a one-cycle pulse on pclk; CYC is at least 3.
`timescale 1ns/10ps
module asb_conv_timer import asb_pkg::*; #(
   parameter int CYC = CONV_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic start,
   output logic busy,
   output logic expire
);
   localparam int CNT_W = $clog2(CYC);
   localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYC - 2);

   logic [CNT_W-1:0] cnt;

   // A start while running reloads the interval
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         busy <= 1'b0;
      end else if (start) begin
         cnt <= LOAD;
         busy <= 1'b1;
      end else if (busy && cnt == '0) begin
         busy <= 1'b0;
      end else if (busy) begin
         cnt <= cnt - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         expire <= 1'b0;
      end else begin
         expire <= busy && cnt == '0 && !start;
      end
   end
endmodule

// >>> design/asb_seq.sv
// Converter sequencer: APB register file, start logic, timing, interrupt.
// Assumes an APB master on pclk and a converter whose data is stable
// on adc_data when the conversion interval ends.
// Operation
// - Control/status and result registers exist
// - One control write sets range, channel, starts
// - Result is ten bits, unipolar
// - Two-bit code picks one of four ranges
// - Six-bit channel field in control word
// - Four to thirty-two channels, groups of four
// - Conversion ends within 22 us, bipolar 29
// - Control bit picks interrupting or polled mode
// - Interrupt on finished conversion
// - Start during conversion flags error, interrupts
// - Polled mode raises no interrupt
// - External trigger may start conversions instead
// - Result register read returns finished result
`timescale 1ns/10ps
module asb_seq import asb_pkg::*; #(
   parameter int ADDR_W = 12,
   parameter int MUX_GROUPS = 1,
   parameter bit BIPOLAR = 1'b0,
   parameter int RES_W = RESULT_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter and multiplexer
   input wire logic [RES_W-1:0] adc_data,
   output logic adc_start,
   output asb_cmd_t adc_cmd,
   output logic [MAX_GROUPS-1:0] mux_group_en,
   // External triggers
   input wire logic ext_trig_one,
   input wire logic ext_trig_two,
   // Interrupt
   output logic irq
);
   localparam int TIMER_CYC = BIPOLAR ? BIP_CYC : CONV_CYC;

   asb_state_t state;
   asb_mode_t mode;
   logic done;
   logic err;
   logic [RES_W-1:0] result;
   logic [STS_W-1:0] sts;
   logic [STS_W-1:0] msk;
   logic [2:0] sync_one;
   logic [2:0] sync_two;
   logic lvl_one;
   logic lvl_two;
   logic ext_edge;
   logic tmr_busy;
   logic expire;
   logic setup;
   logic access;
   logic in_map;
   logic csr_wr;
   logic msk_wr;
   logic sts_rd;
   logic conv_start;
   logic overrun;
   logic [STS_W-1:0] sts_set;
   logic [STS_W-1:0] next_sts;
   logic [31:0] next_rdata;
   logic next_err;

   // Bus decode
   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign in_map = paddr[ADDR_W-1:OFS_W] == '0 && paddr[1:0] == 2'b00;
   assign csr_wr = access && pwrite && in_map && paddr[OFS_W-1:0] == CSR_OFS;
   assign msk_wr = access && pwrite && in_map && paddr[OFS_W-1:0] == MSK_OFS;
   assign sts_rd = access && !pwrite && in_map && paddr[OFS_W-1:0] == STS_OFS;

   // External triggers: three flops, a change counts when the last two agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_one <= 3'h0;
         sync_two <= 3'h0;
      end else begin
         sync_one <= {sync_one[1:0], ext_trig_one};
         sync_two <= {sync_two[1:0], ext_trig_two};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_one <= 1'b0;
         lvl_two <= 1'b0;
      end else begin
         if (sync_one[1] == sync_one[2]) begin
            lvl_one <= sync_one[2];
         end
         if (sync_two[1] == sync_two[2]) begin
            lvl_two <= sync_two[2];
         end
      end
   end

   // Rising edge of the selected trigger input
   always_comb begin
      if (mode.ext_sel) begin
         ext_edge = sync_two[1] == sync_two[2] && sync_two[2] && !lvl_two;
      end else begin
         ext_edge = sync_one[1] == sync_one[2] && sync_one[2] && !lvl_one;
      end
   end

   // A control write starts unless it selects the external trigger
   always_comb begin
      if (csr_wr) begin
         conv_start = !pwdata[CSR_EXT_BIT];
      end else begin
         conv_start = mode.ext_en && ext_edge;
      end
   end

   assign overrun = conv_start && state == ST_CONV;

   asb_conv_timer #(
      .CYC(TIMER_CYC)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(conv_start),
      .busy(tmr_busy),
      .expire(expire)
   );

   // Sequencer state; reset aborts a conversion in progress
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (conv_start) begin
                  state <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (expire && !conv_start) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Mode bits from the control word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= '0;
      end else if (csr_wr) begin
         mode.ie <= pwdata[CSR_IE_BIT];
         mode.ext_en <= pwdata[CSR_EXT_BIT];
         mode.ext_sel <= pwdata[CSR_SEL_BIT];
      end
   end

   // Range and channel go to the analog side with the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_cmd <= '0;
      end else if (csr_wr) begin
         adc_cmd.gain <= asb_gain_t'(pwdata[CSR_GAIN_LSB +: GAIN_W]);
         adc_cmd.channel <= pwdata[CSR_CHAN_LSB +: CHAN_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_start <= 1'b0;
      end else begin
         adc_start <= conv_start;
      end
   end

   // One enable per installed group; uninstalled groups never enable
   for (genvar g = 0; g < MAX_GROUPS; g++) begin : g_grp
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mux_group_en[g] <= 1'b0;
         end else if (csr_wr) begin
            mux_group_en[g] <= g < MUX_GROUPS &&
               pwdata[CSR_CHAN_LSB + GRP_LSB +: GRP_W] == GRP_W'(g);
         end
      end
   end

   // Result capture and done flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= '0;
      end else if (expire && !conv_start) begin
         result <= adc_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
      end else if (conv_start) begin
         done <= 1'b0;
      end else if (expire) begin
         done <= 1'b1;
      end
   end

   // Error holds until a control write that does not itself overrun
   assign next_err = overrun || (err && !csr_wr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err <= 1'b0;
      end else begin
         err <= next_err;
      end
   end

   // Sticky events; a set in the clearing cycle wins
   always_comb begin
      sts_set = '0;
      sts_set[STS_DONE_BIT] = expire && !conv_start;
      sts_set[STS_ERR_BIT] = overrun;
      next_sts = sts_set | (sts_rd ? '0 : sts);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts <= STS_RST;
      end else begin
         sts <= next_sts;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msk <= MSK_RST;
      end else if (msk_wr) begin
         msk <= pwdata[STS_W-1:0];
      end
   end

   // Polled mode keeps the line low whatever the status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= mode.ie && |(sts & msk);
      end
   end

   // Read mux, sampled in the setup cycle
   always_comb begin
      next_rdata = '0;
      if (paddr[OFS_W-1:0] == CSR_OFS) begin
         next_rdata[CSR_GAIN_LSB +: GAIN_W] = adc_cmd.gain;
         next_rdata[CSR_CHAN_LSB +: CHAN_W] = adc_cmd.channel;
         next_rdata[CSR_IE_BIT] = mode.ie;
         next_rdata[CSR_EXT_BIT] = mode.ext_en;
         next_rdata[CSR_SEL_BIT] = mode.ext_sel;
         next_rdata[CSR_BUSY_BIT] = state == ST_CONV;
         next_rdata[CSR_ERR_BIT] = err;
         next_rdata[CSR_DONE_BIT] = done;
      end else if (paddr[OFS_W-1:0] == RES_OFS) begin
         next_rdata[RES_W-1:0] = result;
      end else if (paddr[OFS_W-1:0] == STS_OFS) begin
         next_rdata[STS_W-1:0] = sts;
      end else if (paddr[OFS_W-1:0] == MSK_OFS) begin
         next_rdata[STS_W-1:0] = msk;
      end
   end

   // Zero wait states: answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= RD_RST;
      end else begin
         pready <= setup;
         pslverr <= setup && !in_map;
         prdata <= (setup && !pwrite && in_map) ? next_rdata : RD_RST;
      end
   end

   // Checks
   logic [15:0] conv_age;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_age <= '0;
      end else if (conv_start) begin
         conv_age <= '0;
      end else if (state == ST_CONV) begin
         conv_age <= conv_age + 1'b1;
      end
   end

   AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("pready not a single-cycle answer");

   AST_WRITE_STARTS: assert property (@(posedge pclk) disable iff (!presetn)
      csr_wr && !pwdata[CSR_EXT_BIT] |=> adc_start && state == ST_CONV && !done)
      else $error("control write did not start a conversion");

   AST_CMD_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
      csr_wr |=> adc_cmd == $past(pwdata[CSR_GAIN_LSB +: CHAN_W + GAIN_W]))
      else $error("range or channel not taken from write");

   AST_GROUP_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot0(mux_group_en) && (mux_group_en >> MUX_GROUPS) == '0)
      else $error("bad multiplexer group enable");

   AST_CONV_TIME: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_CONV |-> conv_age < 16'(TIMER_CYC))
      else $error("conversion exceeded its interval");

   AST_IRQ_DONE: assert property (@(posedge pclk) disable iff (!presetn)
      expire && !conv_start && mode.ie && msk[STS_DONE_BIT] && !csr_wr
      |=> ##1 (!mode.ie || !msk[STS_DONE_BIT] || irq))
      else $error("no interrupt after conversion done");

   AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
      overrun |=> err && sts[STS_ERR_BIT])
      else $error("overrun not flagged");

   AST_POLLED_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      !mode.ie |=> !irq)
      else $error("interrupt in polled mode");

   AST_EXT_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
      mode.ext_en && !ext_edge && !csr_wr |=> !adc_start)
      else $error("start without trigger in external mode");

   AST_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
      expire && !conv_start |=> done && result == $past(adc_data))
      else $error("result not captured at end of conversion");

   AST_DONE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      conv_start |=> !done ##0 $stable(result))
      else $error("done not cleared by a new start");

   COV_WRITE_DONE: cover property (@(posedge pclk) disable iff (!presetn)
      csr_wr && !pwdata[CSR_EXT_BIT] ##1 state == ST_CONV [*3] ##[1:1000] done);

   COV_OVERRUN: cover property (@(posedge pclk) disable iff (!presetn)
      overrun);

   COV_EXT_START: cover property (@(posedge pclk) disable iff (!presetn)
      mode.ext_en && ext_edge);

   COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(irq));
endmodule

// >>> tb/asb_adc_model.sv
// Converter stand-in: returns a code made from the command word.
// Assumes adc_start is a one-cycle pulse on pclk; data churns until it settles.
`timescale 1ns/10ps
module asb_adc_model import asb_pkg::*; #(
   parameter int CYC = CONV_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Converter
   input wire logic adc_start,
   input wire asb_cmd_t adc_cmd,
   output logic [RESULT_W-1:0] adc_data
);
   int cnt;
   logic [RESULT_W-1:0] code;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         code <= '0;
         adc_data <= 10'h155;
      end else begin
         if (adc_start) begin
            cnt <= CYC;
            code <= {adc_cmd.gain, adc_cmd.channel, 2'b10};
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
         // Unsettled data flips every cycle so a stale sample shows
         if (cnt > 4) begin
            adc_data <= ~adc_data;
         end else begin
            adc_data <= code;
         end
      end
   end
endmodule

// >>> tb/asb_seq_tb.sv
// Bench for the converter sequencer: APB master tasks, queued read checks.
// Assumes zero-wait APB answers and the converter stand-in model.
`timescale 1ns/10ps
module asb_seq_tb import asb_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_val;
   logic [9:0] adc_data;
   logic adc_start, ext_trig_one, ext_trig_two, irq, no_irq;
   asb_cmd_t adc_cmd;
   logic [7:0] mux_group_en;
   logic [32:0] eq[$], mq[$];
   logic [31:0] cw;
   int err_count, checked, starts, seed, i, n;
   localparam logic [32:0] FULL = 33'h1_ffff_ffff;
   localparam logic [32:0] CSRM = 33'h1_0000_e7ff;

   asb_seq #(.MUX_GROUPS(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_data(adc_data), .adc_start(adc_start),
      .adc_cmd(adc_cmd), .mux_group_en(mux_group_en), .ext_trig_one(ext_trig_one),
      .ext_trig_two(ext_trig_two), .irq(irq));
   asb_adc_model model (.pclk(pclk), .presetn(presetn), .adc_start(adc_start),
      .adc_cmd(adc_cmd), .adc_data(adc_data));

   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end

   task chk(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task complete_run;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [32:0] e, input logic [32:0] m);
      int k;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      eq.push_back(e & m);
      mq.push_back(m);
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd_val = prdata;
      psel <= 0;
      penable <= 0;
      if (k >= 20) chk(0, 1);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1, a, d, 0, FULL);
   endtask

   // Control write, then the one-cycle start pulse and the decoded selects
   task start_cmd(input logic ie, input logic ext, input logic sel, input logic [1:0] g);
      logic [5:0] ch;
      ch = 6'($random(seed));
      cw = {21'h0, sel, ext, ie, ch, g};
      wr(CSR_OFS, cw);
      @(negedge pclk);
      chk(adc_cmd, {ch, g});
      chk(adc_start, !ext);
      chk(mux_group_en, ch[4:2] < 2 ? 8'h1 << ch[4:2] : 8'h0);
   endtask

   task wait_irq(input int lo, input int hi);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      chk(n >= lo && n <= hi, 1);
   endtask

   task tdone(input string s);
      $display("test %0s done", s);
   endtask

   always @(posedge pclk) begin
      if (adc_start === 1'b1) starts++;
      if (no_irq && irq !== 1'b0) chk(irq, 0);
      if (psel && penable && pready === 1'b1 && eq.size() > 0) begin
         chk({pslverr, prdata} & mq[0], eq[0]);
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
   end

   initial begin
      // About four times the length of the full test list
      #(40 * 20000);
      chk(0, 1);
      complete_run;
   end

   initial begin
      {psel, penable, pwrite, ext_trig_one, ext_trig_two, no_irq} = 0;
      paddr = 0;
      pwdata = 0;
      err_count = 0;
      checked = 0;
      starts = 0;
      seed = 52381;
      presetn = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      xfer(0, CSR_OFS, 0, 0, FULL);
      xfer(0, RES_OFS, 0, 0, FULL);
      xfer(0, STS_OFS, 0, {1'b0, 30'h0, STS_RST}, FULL);
      xfer(0, MSK_OFS, 0, {1'b0, 30'h0, MSK_RST}, FULL);
      xfer(0, 12'h010, 0, 33'h1_0000_0000, FULL);
      wr(MSK_OFS, 32'h3);
      xfer(0, MSK_OFS, 0, 3, FULL);
      tdone("reset and map");
      for (i = 0; i < 4; i++) begin
         start_cmd(1, 0, 0, 2'(i));
         wait_irq(548, 556);
         xfer(0, CSR_OFS, 0, cw | 32'h8000, CSRM);
         xfer(0, RES_OFS, 0, {cw[1:0], cw[7:2], 2'b10}, 33'h1_0000_03ff);
         xfer(0, STS_OFS, 0, 1, FULL);
         xfer(0, STS_OFS, 0, 0, FULL);
         chk(irq, 0);
      end
      tdone("interrupt mode");
      start_cmd(1, 0, 0, 2);
      start_cmd(1, 0, 0, 1);
      wait_irq(0, 4);
      xfer(0, CSR_OFS, 0, cw | 32'h6000, CSRM);
      xfer(0, STS_OFS, 0, 2, FULL);
      // The line drops one edge after the clearing read; let it settle first
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      wait_irq(530, 556);
      xfer(0, RES_OFS, 0, {cw[1:0], cw[7:2], 2'b10}, 33'h1_0000_03ff);
      xfer(0, STS_OFS, 0, 1, FULL);
      tdone("overrun");
      start_cmd(0, 0, 0, 3);
      no_irq = 1;
      n = 0;
      do begin
         xfer(0, CSR_OFS, 0, cw, 33'h1_0000_47ff);
         n++;
      end while (rd_val[15] !== 1'b1 && n < 300);
      chk(n < 300, 1);
      xfer(0, RES_OFS, 0, {cw[1:0], cw[7:2], 2'b10}, 33'h1_0000_03ff);
      xfer(0, STS_OFS, 0, 1, FULL);
      no_irq = 0;
      tdone("polled mode");
      for (i = 0; i < 2; i++) begin
         start_cmd(1, 1, 1'(i), 0);
         n = starts;
         ext_trig_one <= 1'(i);
         ext_trig_two <= !i;
         repeat (20) @(posedge pclk);
         chk(starts, n);
         ext_trig_one <= !i;
         ext_trig_two <= i;
         wait_irq(548, 566);
         xfer(0, RES_OFS, 0, {cw[1:0], cw[7:2], 2'b10}, 33'h1_0000_03ff);
         xfer(0, STS_OFS, 0, 1, FULL);
         ext_trig_one <= 0;
         ext_trig_two <= 0;
      end
      tdone("external trigger");
      start_cmd(1, 0, 0, 1);
      repeat (100) @(posedge pclk);
      presetn <= 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      no_irq = 1;
      xfer(0, CSR_OFS, 0, 0, CSRM);
      xfer(0, STS_OFS, 0, 0, FULL);
      repeat (600) @(posedge pclk);
      tdone("reset abort");
      complete_run;
   end
endmodule
